// file: logic/pansr_latch_hi.v
// Purpose: sticky latched-high status bit cleared by a register read
// Assumes: event and read strobe are one-cycle pulses on clk_i
// Notes: an event in the clearing cycle keeps the bit set
`timescale 1ns/10ps
`default_nettype none
module pansr_latch_hi (
	// clock and reset
	input  wire clk_i,
	input  wire sys_rst_i,
	// event and clear
	input  wire event_i,
	input  wire rd_clr_i,
	output reg  flag_o
);
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			flag_o <= 1'b0;
		end else if (event_i) begin
			flag_o <= 1'b1;
		end else if (rd_clr_i) begin
			flag_o <= 1'b0;
		end
	end
endmodule // pansr_latch_hi
`default_nettype wire

// file: logic/pansr_regs.vh
// Purpose: constants for the partner ability, expansion and port status registers
// Assumes: 5-bit management register address, 16-bit data
// Notes: one header, included only by the status register design file
`ifndef PANSR_REGS_VH
`define PANSR_REGS_VH

`define PANSR_ADDR_W        5
`define PANSR_DATA_W        16
`define PANSR_OFS_PARTNER   5'h05
`define PANSR_OFS_EXPAND    5'h06
`define PANSR_OFS_PSTAT     5'h10
`define PANSR_RSV_LO        5'h08
`define PANSR_RSV_HI        5'h0F

`define PANSR_PA_NEXT_PAGE  15
`define PANSR_PA_ACK        14
`define PANSR_PA_RFAULT     13
`define PANSR_PA_PAUSE      10
`define PANSR_PA_TECH_LO    5
`define PANSR_PA_SEL_HI     4

`define PANSR_EX_PD_FAULT   4
`define PANSR_EX_LP_NP_ABLE 3
`define PANSR_EX_NP_ABLE    2
`define PANSR_EX_PAGE_RX    1
`define PANSR_EX_LP_AN_ABLE 0

`define PANSR_PS_SYNC       11
`define PANSR_PS_PD100      10
`define PANSR_PS_PD10       9
`define PANSR_PS_POLARITY   8
`define PANSR_PS_WR_ZERO    7
`define PANSR_PS_ADDR_LO    2
`define PANSR_PS_SPEED      1
`define PANSR_PS_DUPLEX     0

`define PANSR_RST_WORD      16'h0000

`endif

// file: logic/pansr_status_regs.v
// Purpose: read side of partner ability, expansion and port status registers
// Assumes: management frame engine supplies register address and read/write strobes
// Notes: read data is registered one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`include "pansr_regs.vh"

// How it works
// - acknowledge bit set once partner advertisement received successfully
// - partner pause and technology capability bits shown read-only
// - partner next-page, remote-fault and selector copied into ability register
// - parallel detection fault bit latched high, self-clearing, resets zero
// - expansion reports partner next-page ability, zero by default
// - local next-page-able bit always reads zero
// - page-received bit latched high on new page, self-clearing
// - partner negotiation-able bit set when partner can negotiate
// - addresses eight through fifteen implement nothing and read zero
// - receive de-serializer sync state shown in read-only bit
// - 100BASE-TX power-down status reads one while powered down
// - 10BASE-T power-down status reads one while powered down
// - 10BASE-T receive polarity bit, one means reversed
// - five-bit address from two straps and three-bit port index
// - speed bit one means 100M, duplex bit one means full
// - self-clearing bits clear after a management read of their register
module pansr_status_regs #(
	parameter PORT_INDEX = 3'h0
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        sys_rst_i,
	// management register access
	input  wire [4:0]  reg_addr_i,
	input  wire        reg_rd_i,
	input  wire        reg_wr_i,
	input  wire [15:0] reg_wdata_i,
	output reg  [15:0] reg_rdata_o,
	output reg         reg_rvalid_o,
	output wire        reg_hit_o,
	// negotiation engine results, same clock
	input  wire        lp_page_valid_i,
	input  wire [15:0] lp_base_page_i,
	input  wire        lp_ack_rx_i,
	input  wire        pd_fault_event_i,
	input  wire        page_rx_event_i,
	input  wire        lp_an_able_i,
	input  wire        speed_100_i,
	input  wire        full_duplex_i,
	// analog section status, asynchronous
	input  wire        rx_desync_ok_i,
	input  wire        pd100_i,
	input  wire        pd10_i,
	input  wire        pol_rev_i,
	// address straps, asynchronous
	input  wire [1:0]  address_strap_pins_i,
	// captured straps for observation
	output wire [4:0]  phy_addr_o
);
	reg  [15:0] lp_page_reg;
	reg         lp_ack_reg;
	reg         lp_an_able_reg;
	reg         speed_reg;
	reg         duplex_reg;
	reg  [1:0]  strap_reg;
	reg  [15:0] rdata_next;
	wire        pd_fault_flag;
	wire        page_rx_flag;
	wire        sync_s;
	wire        pd100_s;
	wire        pd10_s;
	wire        pol_s;
	wire [1:0]  strap_s;
	wire        rd_expand;
	wire        in_map;

	// asynchronous status through three-flop synchronisers
	pansr_sync3 u_sync_desync (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i  (rx_desync_ok_i),
		.level_o  (sync_s)
	);

	pansr_sync3 u_sync_pd100 (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i  (pd100_i),
		.level_o  (pd100_s)
	);

	pansr_sync3 u_sync_pd10 (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i  (pd10_i),
		.level_o  (pd10_s)
	);

	pansr_sync3 u_sync_pol (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i  (pol_rev_i),
		.level_o  (pol_s)
	);

	// straps are levels too, one more flop before use
	pansr_sync3 u_sync_st0 (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i  (address_strap_pins_i[0]),
		.level_o  (strap_s[0])
	);

	pansr_sync3 u_sync_st1 (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i  (address_strap_pins_i[1]),
		.level_o  (strap_s[1])
	);

	assign rd_expand = reg_rd_i && (reg_addr_i == `PANSR_OFS_EXPAND);

	pansr_latch_hi u_pd_fault (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.event_i  (pd_fault_event_i),
		.rd_clr_i (rd_expand),
		.flag_o   (pd_fault_flag)
	);

	pansr_latch_hi u_page_rx (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.event_i  (page_rx_event_i),
		.rd_clr_i (rd_expand),
		.flag_o   (page_rx_flag)
	);

	// captured state from the negotiation engine
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			lp_page_reg    <= `PANSR_RST_WORD;
			lp_ack_reg     <= 1'b0;
			lp_an_able_reg <= 1'b0;
			speed_reg      <= 1'b0;
			duplex_reg     <= 1'b0;
			strap_reg      <= 2'h0;
		end else begin
			if (lp_page_valid_i) begin
				lp_page_reg <= lp_base_page_i;
			end
			lp_ack_reg     <= lp_ack_rx_i;
			lp_an_able_reg <= lp_an_able_i;
			speed_reg      <= speed_100_i;
			duplex_reg     <= full_duplex_i;
			strap_reg      <= strap_s;
		end
	end

	assign phy_addr_o = {strap_reg, PORT_INDEX[2:0]};

	assign in_map = (reg_addr_i == `PANSR_OFS_PARTNER) ||
		(reg_addr_i == `PANSR_OFS_EXPAND) ||
		(reg_addr_i == `PANSR_OFS_PSTAT);
	assign reg_hit_o = in_map;

	// read mux
	always @* begin
		rdata_next = `PANSR_RST_WORD;
		case (reg_addr_i)
			`PANSR_OFS_PARTNER: begin
				rdata_next[`PANSR_PA_NEXT_PAGE] = lp_page_reg[`PANSR_PA_NEXT_PAGE];
				rdata_next[`PANSR_PA_RFAULT]    = lp_page_reg[`PANSR_PA_RFAULT];
				rdata_next[`PANSR_PA_SEL_HI:0]  = lp_page_reg[`PANSR_PA_SEL_HI:0];
				rdata_next[`PANSR_PA_ACK]       = lp_ack_reg;
				rdata_next[`PANSR_PA_PAUSE:`PANSR_PA_TECH_LO] =
					lp_page_reg[`PANSR_PA_PAUSE:`PANSR_PA_TECH_LO];
			end
			`PANSR_OFS_EXPAND: begin
				rdata_next[`PANSR_EX_PD_FAULT]   = pd_fault_flag;
				rdata_next[`PANSR_EX_LP_NP_ABLE] = lp_page_reg[`PANSR_PA_NEXT_PAGE];
				rdata_next[`PANSR_EX_NP_ABLE]    = 1'b0;
				rdata_next[`PANSR_EX_PAGE_RX]    = page_rx_flag;
				rdata_next[`PANSR_EX_LP_AN_ABLE] = lp_an_able_reg;
			end
			`PANSR_OFS_PSTAT: begin
				rdata_next[`PANSR_PS_SYNC]     = sync_s;
				rdata_next[`PANSR_PS_PD100]    = pd100_s;
				rdata_next[`PANSR_PS_PD10]     = pd10_s;
				rdata_next[`PANSR_PS_POLARITY] = pol_s;
				rdata_next[`PANSR_PS_WR_ZERO]  = 1'b0;
				rdata_next[6:`PANSR_PS_ADDR_LO] = phy_addr_o;
				rdata_next[`PANSR_PS_SPEED]    = speed_reg;
				rdata_next[`PANSR_PS_DUPLEX]   = duplex_reg;
			end
			default: begin
				rdata_next = `PANSR_RST_WORD;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o  <= `PANSR_RST_WORD;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= rdata_next;
			end
		end
	end

	// write port accepted and dropped
	wire unused_wr = reg_wr_i ^ (^reg_wdata_i);
endmodule // pansr_status_regs
`default_nettype wire

// file: logic/pansr_sync3.v
// Purpose: three-stage synchroniser for one asynchronous level
// Assumes: output changes only when stages two and three agree
// Notes: stage one feeds nothing but stage two
`timescale 1ns/10ps
`default_nettype none
module pansr_sync3 #(
	parameter RST_VAL = 1'b0
) (
	// clock and reset
	input  wire clk_i,
	input  wire sys_rst_i,
	// level
	input  wire async_i,
	output reg  level_o
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			s1_reg  <= RST_VAL;
			s2_reg  <= RST_VAL;
			s3_reg  <= RST_VAL;
			level_o <= RST_VAL;
		end else begin
			s1_reg <= async_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_o <= s3_reg;
			end
		end
	end
endmodule // pansr_sync3
`default_nettype wire

// file: verif/pansr_mgmt_host.sv
// Purpose: station manager issuing register reads and writes
// Assumes: strobes taken on the rising edge
// Notes: after a read the released address shows the inverse of the last one; a write leaves it
`timescale 1ns/10ps
`default_nettype none
module pansr_mgmt_host (
	// clock
	input  wire logic        clk_i,
	// register access
	output logic      [4:0]  reg_addr_o,
	output logic             reg_rd_o,
	output logic             reg_wr_o,
	output logic      [15:0] reg_wdata_o,
	input  wire logic [15:0] reg_rdata_i
);
	initial begin
		reg_addr_o = 5'h1F;
		reg_rd_o = 1'h0;
		reg_wr_o = 1'h0;
		reg_wdata_o = 16'hFFFF;
	end
	// n back-to-back reads, last word returned
	task automatic rd(input logic [4:0] a, input int n, output logic [15:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'h1;
		repeat (n) @(posedge clk_i);
		reg_rd_o <= 1'h0;
		reg_addr_o <= ~a;
		@(posedge clk_i);
		d = reg_rdata_i;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_wr_o <= 1'h1;
		reg_wdata_o <= v & 16'hFF7F;
		@(posedge clk_i);
		reg_wr_o <= 1'h0;
		reg_wdata_o <= ~v;
	endtask
endmodule // pansr_mgmt_host
`default_nettype wire

// file: verif/pansr_sr_assertions.sv
// Purpose: port checks of the status register block
// Assumes: one clock, synchronous reset
// Notes: bound to the design top below
`timescale 1ns/10ps
`default_nettype none
module pansr_sr_chk #(
	parameter PORT_INDEX = 3'h0
) (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	// register access
	input wire logic [4:0]  reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        reg_rvalid_o,
	input wire logic        reg_hit_o,
	input wire logic [4:0]  phy_addr_o,
	// engine results
	input wire logic        lp_ack_rx_i,
	input wire logic        pd_fault_event_i,
	input wire logic        page_rx_event_i,
	input wire logic        lp_an_able_i,
	input wire logic        speed_100_i,
	input wire logic        full_duplex_i
);
	wire rd5    = reg_rd_i && reg_addr_i == 5'h05;
	wire rd6    = reg_rd_i && reg_addr_i == 5'h06;
	wire rd16   = reg_rd_i && reg_addr_i == 5'h10;
	wire rd_rsv = reg_rd_i && reg_addr_i[4:3] == 2'h1;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
	rsv_zero_a: assert property (rd_rsv |=> reg_rdata_o == 16'h0000) else $error("reserved read");
	ack_live_a: assert property (rd5 && !$past(sys_rst_i)
		|=> reg_rdata_o[14] == $past(lp_ack_rx_i, 2)) else $error("ack bit wrong");
	exp_const_a: assert property (rd6 |=> reg_rdata_o[15:5] == 11'h000 && !reg_rdata_o[2])
		else $error("expansion constant bits");
	ps_fixed_a: assert property (rd16 |=> reg_rdata_o[15:12] == 4'h0 && !reg_rdata_o[7]
		&& reg_rdata_o[4:2] == PORT_INDEX) else $error("status fixed bits");
	port_idx_a: assert property (rd16 |=> reg_rdata_o[6:2] == $past(phy_addr_o)) else $error("port index");
	rvalid_pulse_a: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
	hit_decode_a: assert property (reg_hit_o == (reg_addr_i == 5'h05 || reg_addr_i == 5'h06
		|| reg_addr_i == 5'h10)) else $error("address hit wrong");
	speed_dup_a: assert property (rd16 && !$past(sys_rst_i) |=> reg_rdata_o[1] == $past(speed_100_i, 2)
		&& reg_rdata_o[0] == $past(full_duplex_i, 2)) else $error("speed or duplex");
	an_able_a: assert property (rd6 && !$past(sys_rst_i)
		|=> reg_rdata_o[0] == $past(lp_an_able_i, 2)) else $error("able bit wrong");
	sticky_set_a: assert property (rd6 && $past(pd_fault_event_i) && !$past(sys_rst_i)
		|=> reg_rdata_o[4]) else $error("fault flag lost");
	self_clear_a: assert property (rd6 && !pd_fault_event_i && !page_rx_event_i ##1 rd6
		|=> reg_rdata_o[4] == 1'h0 && reg_rdata_o[1] == 1'h0) else $error("flags not cleared");
	cover property (rd6 ##1 rd6);
	cover property (rd_rsv);
	cover property (pd_fault_event_i ##[1:20] rd6);
endmodule // pansr_sr_chk
bind pansr_status_regs pansr_sr_chk #(.PORT_INDEX(PORT_INDEX)) u_chk (.clk_i, .sys_rst_i, .reg_addr_i,
	.reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .reg_hit_o, .phy_addr_o, .lp_ack_rx_i, .pd_fault_event_i,
	.page_rx_event_i, .lp_an_able_i, .speed_100_i, .full_duplex_i);
`default_nettype wire

// file: verif/testbench.sv
// Purpose: random and corner checks of the status registers
// Assumes: port index parameter set to five
// Notes: async levels settle well within eight cycles
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk_i = 1'h0;
	logic        sys_rst_i = 1'h1;
	logic [4:0]  reg_addr_i;
	logic        reg_rd_i, reg_wr_i;
	logic [15:0] reg_wdata_i, reg_rdata_o, lp_base_page_i, d;
	logic        lp_page_valid_i = 1'h0, lp_ack_rx_i = 1'h0, pd_fault_event_i = 1'h0, page_rx_event_i = 1'h0;
	logic        lp_an_able_i = 1'h0, speed_100_i = 1'h0, full_duplex_i = 1'h0, rx_desync_ok_i = 1'h0;
	logic        pd100_i = 1'h0, pd10_i = 1'h0, pol_rev_i = 1'h0;
	logic [1:0]  address_strap_pins_i = 2'h0;
	logic [4:0]  phy_addr_o;
	int          errors = 0, checked = 0;
	always #50 clk_i = ~clk_i;
	pansr_status_regs #(.PORT_INDEX(3'h5)) uut (.clk_i, .sys_rst_i, .reg_addr_i, .reg_rd_i, .reg_wr_i,
		.reg_wdata_i, .reg_rdata_o, .reg_rvalid_o(), .reg_hit_o(), .lp_page_valid_i, .lp_base_page_i,
		.lp_ack_rx_i, .pd_fault_event_i, .page_rx_event_i, .lp_an_able_i, .speed_100_i, .full_duplex_i,
		.rx_desync_ok_i, .pd100_i, .pd10_i, .pol_rev_i, .address_strap_pins_i, .phy_addr_o);
	pansr_mgmt_host host (.clk_i, .reg_addr_o(reg_addr_i), .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i),
		.reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
	function automatic logic [15:0] exp_pa(input logic [15:0] p, input logic a);
		return {p[15], a, p[13], 2'h0, p[10:0]};
	endfunction
	function automatic logic [15:0] exp_ps();
		return {4'h0, rx_desync_ok_i, pd100_i, pd10_i, pol_rev_i, 1'h0, address_strap_pins_i, 3'h5,
			speed_100_i, full_duplex_i};
	endfunction
	task automatic cmp(input logic [15:0] got, input logic [15:0] want);
		checked++;
		if (got !== want) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		errors++;
		tally_and_finish;
	end
	initial begin
		lp_base_page_i = 16'h0000;
		void'($urandom(32'h7E47));
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		host.rd(5'h05, 1, d);
		cmp(d, 16'h0000);
		host.rd(5'h06, 1, d);
		cmp(d, 16'h0000);
		host.rd(5'h10, 1, d);
		cmp(d, 16'h0014);
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_i);
			lp_base_page_i <= 16'($urandom);
			lp_page_valid_i <= 1'h1;
			{lp_ack_rx_i, lp_an_able_i, speed_100_i, full_duplex_i} <= 4'($urandom);
			{rx_desync_ok_i, pd100_i, pd10_i, pol_rev_i} <= 4'($urandom);
			address_strap_pins_i <= 2'($urandom);
			pd_fault_event_i <= i[0];
			page_rx_event_i <= i[1];
			@(posedge clk_i);
			{lp_page_valid_i, pd_fault_event_i, page_rx_event_i} <= 3'h0;
			repeat (8) @(posedge clk_i);
			host.rd(5'h05, 1, d);
			cmp(d, exp_pa(lp_base_page_i, lp_ack_rx_i));
			host.rd(5'h10, 1, d);
			cmp(d, exp_ps());
			cmp({11'h000, phy_addr_o}, {11'h000, address_strap_pins_i, 3'h5});
			host.rd(5'h06, 1, d);
			cmp(d, {11'h000, i[0], lp_base_page_i[15], 1'h0, i[1], lp_an_able_i});
			host.rd(5'h06, 2, d);
			cmp(d, {12'h000, lp_base_page_i[15], 2'h0, lp_an_able_i});
			host.wr(5'h10, 16'($urandom));
			host.rd(5'h10, 1, d);
			cmp(d, exp_ps());
			host.rd(5'h08 + 5'(i % 8), 1, d);
			cmp(d, 16'h0000);
		end
		fork
			host.rd(5'h06, 1, d);
			begin
				@(posedge clk_i);
				pd_fault_event_i <= 1'h1;
				@(posedge clk_i);
				pd_fault_event_i <= 1'h0;
			end
		join
		host.rd(5'h06, 1, d);
		cmp(d & 16'h0010, 16'h0010);
		// mid-run reset drops freshly latched flags
		@(posedge clk_i);
		{pd_fault_event_i, page_rx_event_i} <= 2'h3;
		@(posedge clk_i);
		{pd_fault_event_i, page_rx_event_i} <= 2'h0;
		sys_rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		host.rd(5'h06, 1, d);
		cmp(d, {15'h0000, lp_an_able_i});
		host.rd(5'h05, 1, d);
		cmp(d, {1'h0, lp_ack_rx_i, 14'h0000});
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
